// ### aea_apparent_energy_accumulator.sv
// Apparent energy accumulator: two-stage VA-hour integration with register port
module aea_apparent_energy_accumulator
   import aea_pkg::*;
#(
   parameter int PHASES = AEA_PHASES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire aea_host_req_s host_req,
   output logic [31:0] host_rdata,
   input wire aea_dsp_in_s dsp_in,
   input wire logic [2:0] zero_cross,
   output logic sample_tick,
   output logic interrupt_line_zero_n
);

   typedef struct packed {
      logic [AEA_TICK_W-1:0] tick_cnt;
      logic tick;
      logic [23:0] thr_high;
      logic [23:0] thr_low;
      logic signed [PHASES-1:0][AEA_ACC1_W-1:0] stage1;
      logic [PHASES-1:0][31:0] pulse_cnt;
      logic [PHASES-1:0][31:0] energy;
      logic [7:0] line_cycle_config;
      logic [7:0] accumulation_config;
      logic [15:0] half_cycle_count;
      logic [15:0] zc_seen;
      logic half_full;
      logic data_ready;
      logic [31:0] mask;
      logic [31:0] rdata;
      logic irq_n;
   } aea_state_s;

   aea_state_s st;
   aea_state_s next_st;

   logic [31:0] wave_word;
   logic wave_fresh;

   // ---------------------------------------------------------------------
   // Waveform sample registers
   // ---------------------------------------------------------------------
   aea_wave_capture #(
      .NREGS(AEA_WAVE_REGS)
   ) u_wave (
      .core_clk(core_clk),
      .rstn(rstn),
      .sample_tick(st.tick),
      .samples_in(dsp_in.wave),
      .read_index(host_req.addr[3:0]),
      .read_word(wave_word),
      .samples_fresh(wave_fresh)
   );

   // Byte lanes enabled by the transfer size
   function automatic logic [31:0] size_mask(input aea_size_e sz);
      case (sz)
         AEA_SIZE_8: size_mask = 32'h000000ff;
         AEA_SIZE_16: size_mask = 32'h0000ffff;
         AEA_SIZE_32: size_mask = 32'hffffffff;
         default: size_mask = 32'h00000000;
      endcase
   endfunction

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      logic [AEA_ACC1_W-1:0] thr;
      logic signed [AEA_ACC1_W-1:0] sum;
      logic signed [AEA_ACC1_W-1:0] pw;
      logic [PHASES-1:0] pulse;
      logic [31:0] bump;
      logic [31:0] wmask;
      logic [31:0] rword;
      logic [31:0] wval;
      logic line_mode;
      logic clr_read;
      logic zc_hit;
      logic zc_done;
      logic hf_event;
      logic acc_read;
      logic [1:0] rd_phase;
      logic [15:0] zc_target;
      thr = '0;
      sum = '0;
      pw = '0;
      pulse = '0;
      bump = '0;
      wmask = '0;
      rword = '0;
      wval = '0;
      line_mode = 1'b0;
      clr_read = 1'b0;
      zc_hit = 1'b0;
      zc_done = 1'b0;
      hf_event = 1'b0;
      acc_read = 1'b0;
      rd_phase = '0;
      zc_target = '0;
      next_st = st;

      // Sample tick divider: one pulse per sample period
      next_st.tick = 1'b0;
      if (st.tick_cnt == AEA_TICK_W'(AEA_SAMPLE_CYCLES - 1)) begin
         next_st.tick_cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + AEA_TICK_W'(1);
      end

      line_mode = st.line_cycle_config[AEA_LC_APPARENT_ENABLE_BIT];
      // Clear-on-read has no meaning once line cycle mode owns the update
      clr_read = st.line_cycle_config[AEA_LC_CLEAR_ON_READ_BIT] && !line_mode;
      thr = {1'b0, st.thr_high, st.thr_low};

      // First stage: threshold accumulator per phase
      for (int p = 0; p < PHASES; p++) begin
         pw = AEA_ACC1_W'(dsp_in.va[p]);
         if (p == 1 && st.accumulation_config[AEA_ACC_PHASE_SEL_LSB +: 2] ==
             AEA_PHASE_SEL_B_ZERO) begin
            pw = '0;
         end
         if (st.tick) begin
            sum = st.stage1[p] + pw;
            if (sum >= $signed(thr)) begin
               pulse[p] = 1'b1;
               sum = sum - $signed(thr);
            end
            next_st.stage1[p] = sum;
         end
      end

      // Second stage: pulse counters, wrap to zero
      for (int p = 0; p < PHASES; p++) begin
         bump = st.pulse_cnt[p] + 32'(pulse[p]);
         if (bump[AEA_HALF_FULL_WATCH_BIT] != st.pulse_cnt[p][AEA_HALF_FULL_WATCH_BIT]) begin
            hf_event = 1'b1;
         end
         next_st.pulse_cnt[p] = bump;
      end

      // Line cycle synchronisation
      zc_hit = |(zero_cross & st.line_cycle_config[AEA_LC_ZX_SEL_LSB +: 3]);
      zc_target = (st.half_cycle_count == 16'h0000) ? 16'h0001 : st.half_cycle_count;
      if (line_mode && zc_hit) begin
         if (st.zc_seen + 16'h0001 >= zc_target) begin
            zc_done = 1'b1;
            next_st.zc_seen = '0;
         end else begin
            next_st.zc_seen = st.zc_seen + 16'h0001;
         end
      end
      if (!line_mode) begin
         next_st.zc_seen = '0;
      end
      if (zc_done) begin
         for (int p = 0; p < PHASES; p++) begin
            next_st.energy[p] = next_st.pulse_cnt[p];
            next_st.pulse_cnt[p] = 32'(pulse[p]);
         end
      end

      // -------------------------------------------------------------------
      // Register reads
      // -------------------------------------------------------------------
      acc_read = host_req.rd && host_req.addr >= AEA_REG_ENERGY_A &&
                 host_req.addr <= AEA_REG_ENERGY_C;
      rd_phase = 2'(host_req.addr - AEA_REG_ENERGY_A);
      case (host_req.addr)
         AEA_REG_THR_HIGH: rword = {8'h00, st.thr_high};
         AEA_REG_THR_LOW: rword = {8'h00, st.thr_low};
         AEA_REG_ENERGY_A, AEA_REG_ENERGY_B, AEA_REG_ENERGY_C: begin
            rword = line_mode ? st.energy[rd_phase] : st.pulse_cnt[rd_phase];
         end
         AEA_REG_LINE_CYCLE_CONFIG: rword = {24'h000000, st.line_cycle_config};
         AEA_REG_ACCUMULATION_CONFIG: rword = {24'h000000, st.accumulation_config};
         AEA_REG_HALF_CYCLE_COUNT: rword = {16'h0000, st.half_cycle_count};
         AEA_REG_STATUS_WORD_ZERO: begin
            rword = '0;
            rword[AEA_HALF_FULL_BIT] = st.half_full;
            rword[AEA_DATA_READY_BIT] = st.data_ready;
         end
         AEA_REG_INTERRUPT_MASK_ZERO: rword = st.mask;
         default: begin
            rword = (host_req.addr >= AEA_REG_WAVE_BASE) ? wave_word : 32'h00000000;
         end
      endcase
      if (host_req.rd) begin
         next_st.rdata = rword & size_mask(host_req.size);
      end
      if (acc_read && !line_mode) begin
         // Visible copy taken at the access
         next_st.energy[rd_phase] = st.pulse_cnt[rd_phase];
         if (clr_read) begin
            // A pulse landing in the read cycle is kept, not lost
            next_st.pulse_cnt[rd_phase] = 32'(pulse[rd_phase]);
         end
      end

      // -------------------------------------------------------------------
      // Register writes; narrow writes touch only the low lanes
      // -------------------------------------------------------------------
      wmask = size_mask(host_req.size);
      if (host_req.wr) begin
         case (host_req.addr)
            AEA_REG_THR_HIGH: begin
               wval = ({8'h00, st.thr_high} & ~wmask) | (host_req.wdata & wmask);
               next_st.thr_high = wval[23:0];
            end
            AEA_REG_THR_LOW: begin
               wval = ({8'h00, st.thr_low} & ~wmask) | (host_req.wdata & wmask);
               next_st.thr_low = wval[23:0];
            end
            AEA_REG_LINE_CYCLE_CONFIG: begin
               if (wmask[0]) begin
                  next_st.line_cycle_config = host_req.wdata[7:0];
               end
            end
            AEA_REG_ACCUMULATION_CONFIG: begin
               if (wmask[0]) begin
                  next_st.accumulation_config = host_req.wdata[7:0];
               end
            end
            AEA_REG_HALF_CYCLE_COUNT: begin
               wval = ({16'h0000, st.half_cycle_count} & ~wmask) | (host_req.wdata & wmask);
               next_st.half_cycle_count = wval[15:0];
            end
            AEA_REG_STATUS_WORD_ZERO: begin
               wval = host_req.wdata & wmask;
               if (wval[AEA_HALF_FULL_BIT]) begin
                  next_st.half_full = 1'b0;
               end
               if (wval[AEA_DATA_READY_BIT]) begin
                  next_st.data_ready = 1'b0;
               end
            end
            AEA_REG_INTERRUPT_MASK_ZERO: begin
               next_st.mask = (st.mask & ~wmask) | (host_req.wdata & wmask);
            end
            default: begin
               next_st.mask = st.mask;
            end
         endcase
      end

      // Set wins over a same-cycle clear, independent of the mask
      if (hf_event) begin
         next_st.half_full = 1'b1;
      end
      if (wave_fresh) begin
         next_st.data_ready = 1'b1;
      end

      next_st.irq_n = !((next_st.half_full && st.mask[AEA_HALF_FULL_BIT]) ||
                        (next_st.data_ready && st.mask[AEA_DATA_READY_BIT]));
   end

   // ---------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.thr_high <= AEA_THR_HIGH_RESET;
         st.thr_low <= AEA_THR_LOW_RESET;
         st.line_cycle_config <= AEA_LINE_CYCLE_CONFIG_RESET;
         st.accumulation_config <= AEA_ACCUMULATION_CONFIG_RESET;
         st.half_cycle_count <= AEA_HALF_CYCLE_COUNT_RESET;
         st.mask <= AEA_MASK_RESET;
         st.irq_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign host_rdata = st.rdata;
   assign sample_tick = st.tick;
   assign interrupt_line_zero_n = st.irq_n;

endmodule // aea_apparent_energy_accumulator

// ### aea_pkg.sv
// Package: constants, register map and carrier types of the apparent energy accumulator
package aea_pkg;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int AEA_CLK_PERIOD_NS = 40;
   localparam int AEA_SAMPLE_PERIOD_NS = 125000;
   localparam int AEA_SAMPLE_CYCLES = AEA_SAMPLE_PERIOD_NS / AEA_CLK_PERIOD_NS;
   localparam int AEA_TICK_W = 12;

   // ---------------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------------
   localparam int AEA_PHASES = 3;
   localparam int AEA_SAMPLE_W = 24;
   localparam int AEA_WAVE_REGS = 16;
   localparam int AEA_ACC1_W = 49;
   localparam int AEA_ADDR_W = 5;

   // ---------------------------------------------------------------------
   // Register word indices
   // ---------------------------------------------------------------------
   localparam logic [4:0] AEA_REG_THR_HIGH = 5'h00;
   localparam logic [4:0] AEA_REG_THR_LOW = 5'h01;
   localparam logic [4:0] AEA_REG_ENERGY_A = 5'h02;
   localparam logic [4:0] AEA_REG_ENERGY_B = 5'h03;
   localparam logic [4:0] AEA_REG_ENERGY_C = 5'h04;
   localparam logic [4:0] AEA_REG_LINE_CYCLE_CONFIG = 5'h05;
   localparam logic [4:0] AEA_REG_ACCUMULATION_CONFIG = 5'h06;
   localparam logic [4:0] AEA_REG_HALF_CYCLE_COUNT = 5'h07;
   localparam logic [4:0] AEA_REG_STATUS_WORD_ZERO = 5'h08;
   localparam logic [4:0] AEA_REG_INTERRUPT_MASK_ZERO = 5'h09;
   localparam logic [4:0] AEA_REG_WAVE_BASE = 5'h10;

   // ---------------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------------
   localparam int AEA_LC_APPARENT_ENABLE_BIT = 2;
   localparam int AEA_LC_ZX_SEL_LSB = 3;
   localparam int AEA_LC_CLEAR_ON_READ_BIT = 6;
   localparam int AEA_ACC_PHASE_SEL_LSB = 4;
   localparam int AEA_HALF_FULL_BIT = 4;
   localparam int AEA_DATA_READY_BIT = 17;
   localparam int AEA_HALF_FULL_WATCH_BIT = 30;
   localparam logic [1:0] AEA_PHASE_SEL_B_ZERO = 2'h1;

   // ---------------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------------
   localparam logic [23:0] AEA_THR_HIGH_RESET = 24'h000000;
   localparam logic [23:0] AEA_THR_LOW_RESET = 24'h000001;
   localparam logic [7:0] AEA_LINE_CYCLE_CONFIG_RESET = 8'h78;
   localparam logic [7:0] AEA_ACCUMULATION_CONFIG_RESET = 8'h00;
   localparam logic [15:0] AEA_HALF_CYCLE_COUNT_RESET = 16'hffff;
   localparam logic [31:0] AEA_MASK_RESET = 32'h00000000;

   // ---------------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {
      AEA_SIZE_8 = 2'b00,
      AEA_SIZE_16 = 2'b01,
      AEA_SIZE_32 = 2'b10
   } aea_size_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [AEA_ADDR_W-1:0] addr;
      aea_size_e size;
      logic [31:0] wdata;
   } aea_host_req_s;

   typedef logic signed [AEA_SAMPLE_W-1:0] aea_sample_t;

   typedef struct packed {
      aea_sample_t [AEA_PHASES-1:0] va;
      aea_sample_t [AEA_WAVE_REGS-1:0] wave;
   } aea_dsp_in_s;

endpackage : aea_pkg

// ### aea_wave_capture.sv
// Waveform sample registers: capture on each sample tick, sign-extended word read-out
module aea_wave_capture
   import aea_pkg::*;
#(
   parameter int NREGS = AEA_WAVE_REGS
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sample_tick,
   input wire aea_sample_t [NREGS-1:0] samples_in,
   input wire logic [3:0] read_index,
   output logic [31:0] read_word,
   output logic samples_fresh
);

   typedef struct packed {
      aea_sample_t [NREGS-1:0] samples;
      logic fresh;
   } aea_wave_state_s;

   aea_wave_state_s st;
   aea_wave_state_s next_st;

   // ---------------------------------------------------------------------
   // Capture
   // ---------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.fresh = 1'b0;
      if (sample_tick) begin
         next_st.samples = samples_in;
         next_st.fresh = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Sign bit 23 fills the top byte on the read word
   assign read_word = {{8{st.samples[read_index][AEA_SAMPLE_W-1]}},
                       st.samples[read_index]};
   assign samples_fresh = st.fresh;

endmodule // aea_wave_capture

// ### aea_apparent_energy_accumulator_sva.sv
// Checker: port-level assertions for the apparent energy accumulator
module aea_energy_sva
   import aea_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire aea_host_req_s host_req,
   input wire logic [31:0] host_rdata,
   input wire aea_dsp_in_s dsp_in,
   input wire logic [2:0] zero_cross,
   input wire logic sample_tick,
   input wire logic interrupt_line_zero_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ---------------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------------
   logic [11:0] gap;
   logic seen;
   logic [31:0] mask_sh;
   logic mask_wr;
   logic ack_wr;
   assign mask_wr = host_req.wr && host_req.addr == AEA_REG_INTERRUPT_MASK_ZERO
      && host_req.size == AEA_SIZE_32;
   assign ack_wr = host_req.wr && host_req.addr == AEA_REG_STATUS_WORD_ZERO
      && host_req.size == AEA_SIZE_32 && host_req.wdata[17] && host_req.wdata[4];

   // Shadow of the mask, so irq can be tied to what the host enabled
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gap <= '0;
         seen <= 1'b0;
         mask_sh <= '0;
      end else begin
         gap <= sample_tick ? 12'd0 : gap + 12'd1;
         seen <= seen | sample_tick;
         if (mask_wr) begin
            mask_sh <= host_req.wdata;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------------
   property p_tick_period;
      sample_tick && seen |-> gap == 12'(AEA_SAMPLE_CYCLES - 1);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("sample period wrong");

   property p_tick_single;
      sample_tick |=> !sample_tick;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick wider than one");

   property p_irq_masked;
      !interrupt_line_zero_n |-> ((mask_sh | $past(mask_sh)) & 32'h00020010) != 32'h0;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq low while masked");

   property p_irq_ack;
      ack_wr && !sample_tick && !$past(sample_tick) && !$past(sample_tick, 2)
         |-> ##[1:2] interrupt_line_zero_n;
   endproperty
   a_irq_ack: assert property (p_irq_ack) else $error("irq not released");

   property p_ready_irq;
      sample_tick && mask_sh[17] |-> ##[1:3] !interrupt_line_zero_n;
   endproperty
   a_ready_irq: assert property (p_ready_irq) else $error("ready irq missing");

   property p_rdata_hold;
      !host_req.rd |=> $stable(host_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_thr_pad;
      host_req.rd && host_req.addr <= AEA_REG_THR_LOW && host_req.size == AEA_SIZE_32
         |=> host_rdata[31:24] == 8'h00;
   endproperty
   a_thr_pad: assert property (p_thr_pad) else $error("threshold top byte set");

   property p_wave_sext;
      host_req.rd && host_req.addr[4] && host_req.size == AEA_SIZE_32
         |=> host_rdata[31:24] == {8{host_rdata[23]}};
   endproperty
   a_wave_sext: assert property (p_wave_sext) else $error("sample not extended");

   property p_bad_size;
      host_req.rd && host_req.size == 2'b11 |=> host_rdata == 32'h0;
   endproperty
   a_bad_size: assert property (p_bad_size) else $error("bad size read nonzero");

   c_tick: cover property (sample_tick);
   c_irq: cover property ($fell(interrupt_line_zero_n));
   c_wave: cover property (host_req.rd && host_req.addr[4]);
endmodule // aea_energy_sva

bind aea_apparent_energy_accumulator aea_energy_sva u_sva (.core_clk(core_clk), .rstn(rstn),
   .host_req(host_req), .host_rdata(host_rdata), .dsp_in(dsp_in), .zero_cross(zero_cross),
   .sample_tick(sample_tick), .interrupt_line_zero_n(interrupt_line_zero_n));

// ### aea_host_model.sv
// Host model: register port master issuing single-cycle read and write strobes
module aea_host_model
   import aea_pkg::*;
(
   input wire logic core_clk,
   input wire logic [31:0] host_rdata,
   output aea_host_req_s host_req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial host_req = '0;

   // Writes always whole words
   task automatic wr(input logic [4:0] addr, input logic [31:0] data);
      @(posedge core_clk);
      host_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, size: AEA_SIZE_32, wdata: data};
      @(posedge core_clk);
      host_req.wr <= 1'b0;
   endtask

   // Data taken once the strobe edge's update has landed
   task automatic rd(input logic [4:0] addr, input aea_size_e size, output logic [31:0] data);
      @(posedge core_clk);
      host_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, size: size, wdata: 32'h0};
      @(posedge core_clk);
      host_req.rd <= 1'b0;
      #1;
      data = host_rdata;
   endtask
endmodule // aea_host_model

// ### apparent_energy_accumulator_tb.sv
// Testbench: directed scenarios for the apparent energy accumulator
module apparent_energy_accumulator_tb
   import aea_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk;
   logic rstn;
   aea_host_req_s host_req;
   logic [31:0] host_rdata;
   aea_dsp_in_s dsp_in;
   logic [2:0] zero_cross;
   logic sample_tick;
   logic interrupt_line_zero_n;
   int err_total;
   int checks;
   int cycles = 0;
   logic [31:0] d;
   logic [31:0] x0;

   aea_apparent_energy_accumulator uut (.core_clk(core_clk), .rstn(rstn), .host_req(host_req),
      .host_rdata(host_rdata), .dsp_in(dsp_in), .zero_cross(zero_cross),
      .sample_tick(sample_tick), .interrupt_line_zero_n(interrupt_line_zero_n));
   aea_host_model host (.core_clk(core_clk), .host_rdata(host_rdata), .host_req(host_req));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic results();
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // About 12 sample periods are used; ceiling leaves margin
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         results();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rcmp(input logic [4:0] addr, input logic [31:0] exp, input string what);
      host.rd(addr, AEA_SIZE_32, d);
      cmp(d, exp, what);
   endtask

   task automatic tick(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge core_clk);
            k++;
         end while (sample_tick !== 1'b1 && k < 3200);
         if (k >= 3200) cmp(32'h0, 32'h1, "no sample tick");
      end
      @(posedge core_clk);
   endtask

   task automatic zx(input logic [2:0] m);
      @(posedge core_clk);
      zero_cross <= m;
      @(posedge core_clk);
      zero_cross <= 3'b000;
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset();
      rcmp(AEA_REG_THR_HIGH, 32'h0, "thr high reset");
      rcmp(AEA_REG_THR_LOW, 32'h1, "thr low reset");
      rcmp(AEA_REG_LINE_CYCLE_CONFIG, 32'h78, "line cfg reset");
      rcmp(AEA_REG_ACCUMULATION_CONFIG, 32'h0, "acc cfg reset");
      rcmp(AEA_REG_INTERRUPT_MASK_ZERO, 32'h0, "mask reset");
      rcmp(5'h0a, 32'h0, "unmapped");
      host.wr(AEA_REG_THR_HIGH, 32'hffffffff);
      rcmp(AEA_REG_THR_HIGH, 32'h00ffffff, "thr padding");
      host.rd(AEA_REG_THR_HIGH, AEA_SIZE_16, d);
      cmp(d, 32'h0000ffff, "half word read");
      host.rd(AEA_REG_HALF_CYCLE_COUNT, AEA_SIZE_8, d);
      cmp(d, 32'h000000ff, "byte read");
      host.rd(AEA_REG_THR_LOW, aea_size_e'(2'b11), d);
      cmp(d, 32'h0, "bad size");
      host.wr(AEA_REG_THR_HIGH, 32'h0);
      host.wr(AEA_REG_THR_LOW, 32'h64);
   endtask

   task automatic t_energy();
      dsp_in.va[0] <= 24'd60;
      dsp_in.va[1] <= 24'd100;
      dsp_in.va[2] <= 24'd100;
      tick(5);
      rcmp(AEA_REG_ENERGY_A, 32'h3, "A pulses");
      rcmp(AEA_REG_ENERGY_A, 32'h0, "A cleared");
      rcmp(AEA_REG_ENERGY_B, 32'h5, "B pulses");
      host.wr(AEA_REG_ENERGY_C, 32'h1234);
      rcmp(AEA_REG_ENERGY_C, 32'h5, "C read only");
   endtask

   task automatic t_phase_sel();
      host.wr(AEA_REG_ACCUMULATION_CONFIG, 32'h10);
      tick(2);
      rcmp(AEA_REG_ENERGY_B, 32'h0, "B forced zero");
      rcmp(AEA_REG_ENERGY_A, 32'h1, "A unchanged");
      host.wr(AEA_REG_ACCUMULATION_CONFIG, 32'h0);
   endtask

   task automatic t_ready();
      dsp_in.wave[0] <= 24'h800001;
      dsp_in.wave[1] <= 24'h123456;
      tick(1);
      repeat (3) @(posedge core_clk);
      cmp({31'h0, interrupt_line_zero_n}, 32'h1, "irq while masked");
      host.rd(AEA_REG_STATUS_WORD_ZERO, AEA_SIZE_32, d);
      cmp(d & 32'h00020010, 32'h00020000, "ready flag");
      rcmp(AEA_REG_WAVE_BASE, 32'hff800001, "negative sample");
      rcmp(AEA_REG_WAVE_BASE + 5'h01, 32'h00123456, "positive sample");
      host.wr(AEA_REG_STATUS_WORD_ZERO, 32'h00020010);
      host.wr(AEA_REG_INTERRUPT_MASK_ZERO, 32'h00020000);
      tick(1);
      repeat (3) @(posedge core_clk);
      cmp({31'h0, interrupt_line_zero_n}, 32'h0, "irq low");
      host.wr(AEA_REG_STATUS_WORD_ZERO, 32'h00020010);
      repeat (2) @(posedge core_clk);
      cmp({31'h0, interrupt_line_zero_n}, 32'h1, "irq released");
      host.wr(AEA_REG_INTERRUPT_MASK_ZERO, 32'h0);
   endtask

   task automatic t_line_cycle();
      host.wr(AEA_REG_LINE_CYCLE_CONFIG, 32'h14);
      host.wr(AEA_REG_HALF_CYCLE_COUNT, 32'h2);
      zx(3'b010);
      zx(3'b010);
      repeat (2) @(posedge core_clk);
      host.rd(AEA_REG_ENERGY_B, AEA_SIZE_32, x0);
      cmp(x0, 32'h2, "first transfer");
      tick(3);
      rcmp(AEA_REG_ENERGY_B, x0, "held between transfers");
      zx(3'b001);
      zx(3'b010);
      repeat (2) @(posedge core_clk);
      rcmp(AEA_REG_ENERGY_B, x0, "unselected crossing");
      zx(3'b010);
      repeat (2) @(posedge core_clk);
      rcmp(AEA_REG_ENERGY_B, 32'h3, "transfer count");
   endtask

   initial begin
      rstn = 1'b0;
      zero_cross = 3'b000;
      dsp_in = '0;
      err_total = 0;
      checks = 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_energy();
      t_phase_sel();
      t_ready();
      t_line_cycle();
      results();
   end
endmodule // apparent_energy_accumulator_tb
